// [rtl/isf_regs.sv]
/*
  Register slice of a four-channel serial audio controller: fifo flush
  strobes, block dma ports with pointer resets, threshold and build
  parameter registers, on an apb-style slave with wait states.
  Assumes the channel fifos, enables and serial pins sit outside on mclk.
*/
//
// Contract
// - writing one to rx flush bit 0 empties that channel's receive fifo; reads zero.
// - writing one to tx flush bit 0 empties that channel's transmit fifo.
// - rx dma port reads step through enabled channels ascending, wrapping around.
// - each rx channel visit returns left then right before moving on.
// - rx pointer reset returns pointer to lowest enabled channel; self-clearing.
// - tx pointer reset returns pointer to lowest enabled channel; self-clearing.
// - rx sizes register reports per-channel word size fields, bit 6 reserved.
// - word size codes 12..32 bits as 0..4; tx sizes in main register.
// - channel count fields report one to four channels as codes 0..3.
// - fifo depth field reports 2, 4, 8 or 16 entries.
// - bus width field reports 8, 16 or 32 bits, code 3 reserved.
// - version register returns a fixed value; writes ignored.
// - tx empty threshold field per channel, reset value three.
`timescale 1ns/1ps
`default_nettype none

module isf_regs (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // peripheral bus
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // channel enables from the surrounding unit
  input  wire logic [3:0]   rx_chan_en,
  input  wire logic [3:0]   tx_chan_en,
  // receive fifo heads
  input  wire logic [127:0] rx_word_data,
  input  wire logic [3:0]   rx_word_valid,
  output logic [3:0]        rx_word_pop,
  // flush strobes and thresholds
  output logic [3:0]        rx_flush_strobe,
  output logic [3:0]        tx_flush_strobe,
  output logic [15:0]       tx_empty_threshold,
  // transmit word stream
  output logic [31:0]       tx_word_data,
  output logic [1:0]        tx_word_chan,
  output logic              tx_word_right,
  output logic              tx_word_valid,
  input  wire logic         tx_word_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next enabled channel strictly after p, wrapping; p itself is tried last
  function automatic logic [1:0] next_en(input logic [1:0] p, input logic [3:0] en);
    logic [1:0] r;
    logic [1:0] c;
    logic       hit;
    r   = p;
    hit = 1'b0;
    for (int i = 1; i <= isf_pkg::NCHAN; i++) begin
      c = p + 2'(i);
      if (!hit && en[c]) begin
        r   = c;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // lowest enabled channel
  function automatic logic [1:0] lowest_en(input logic [3:0] en);
    return next_en(2'h3, en);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  isf_pkg::isf_state_t s_q;
  isf_pkg::isf_state_t s_d;

  // build parameter words
  logic [31:0] param2;
  logic [31:0] param1;

  assign param2 = {19'h0_0000, isf_pkg::RX_WS3, isf_pkg::RX_WS2, 1'b0,
                   isf_pkg::RX_WS1, isf_pkg::RX_WS0};
  assign param1 = {4'h0, isf_pkg::TX_WS3, isf_pkg::TX_WS2, isf_pkg::TX_WS1,
                   isf_pkg::TX_WS0, 5'h00, isf_pkg::TX_CHAN_CODE,
                   isf_pkg::RX_CHAN_CODE, isf_pkg::HAS_RX_BLOCK,
                   isf_pkg::HAS_TX_BLOCK, isf_pkg::MODE_EN,
                   isf_pkg::FIFO_DEPTH_CODE, isf_pkg::BUS_WIDTH_CODE};

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [3:0]          rx_fl_hit;
    logic [3:0]          tx_fl_hit;
    logic [3:0]          thr_hit;
    logic [1:0]          rx_ch;
    logic [1:0]          tx_ch;
    logic                respond;
    logic                err;
    isf_pkg::isf_txent_t ent;
    rx_fl_hit = 4'h0;
    tx_fl_hit = 4'h0;
    thr_hit   = 4'h0;
    respond   = 1'b0;
    err       = 1'b0;
    rx_ch     = rx_chan_en[s_q.rx_ptr] ? s_q.rx_ptr : next_en(s_q.rx_ptr, rx_chan_en);
    tx_ch     = tx_chan_en[s_q.tx_ptr] ? s_q.tx_ptr : next_en(s_q.tx_ptr, tx_chan_en);
    ent       = '{v: 1'b1, ch: tx_ch, rt: s_q.tx_right, d: pwdata};

    s_d          = s_q;
    s_d.pready   = 1'b0;
    s_d.pslverr  = 1'b0;
    s_d.prdata   = 32'h0000_0000;
    s_d.rx_pop   = 4'h0;
    s_d.rx_flush = 4'h0;
    s_d.tx_flush = 4'h0;
    s_d.st       = isf_pkg::ST_IDLE;

    // per-channel register decode
    for (int c = 0; c < isf_pkg::NCHAN; c++) begin
      rx_fl_hit[c] = paddr == 12'(isf_pkg::RX_FLUSH0_OFF + 12'(c) * isf_pkg::CHAN_STRIDE);
      tx_fl_hit[c] = paddr == 12'(isf_pkg::TX_FLUSH0_OFF + 12'(c) * isf_pkg::CHAN_STRIDE);
      thr_hit[c]   = paddr == 12'(isf_pkg::TX_THR0_OFF + 12'(c) * isf_pkg::CHAN_STRIDE);
    end

    // drain the transmit buffer head when the channel side takes it
    // a drain and a write in one cycle: the drain goes first, but a write that finds e1 full still waits a cycle
    if (s_q.e0.v && tx_word_ready) begin
      s_d.e0   = s_q.e1;
      s_d.e1.v = 1'b0;
    end

    case (s_q.st)
      isf_pkg::ST_IDLE: begin
        if (psel && penable) begin
          if (pwrite) begin
            if (paddr == isf_pkg::TX_DMA_OFF) begin
              if (tx_chan_en == 4'h0) begin
                respond = 1'b1;
                err     = 1'b1;
              end else if (!s_q.e1.v) begin
                if (s_d.e0.v) begin
                  s_d.e1 = ent;
                end else begin
                  s_d.e0 = ent;
                end
                s_d.tx_right = !s_q.tx_right;
                if (s_q.tx_right) begin
                  s_d.tx_ptr = next_en(tx_ch, tx_chan_en);
                end else begin
                  s_d.tx_ptr = tx_ch;
                end
                respond = 1'b1;
              end
            end else if (paddr == isf_pkg::RX_PTR_RST_OFF) begin
              if (pwdata[isf_pkg::CMD_BIT]) begin
                s_d.rx_ptr   = lowest_en(rx_chan_en);
                s_d.rx_right = 1'b0;
              end
              respond = 1'b1;
            end else if (paddr == isf_pkg::TX_PTR_RST_OFF) begin
              if (pwdata[isf_pkg::CMD_BIT]) begin
                s_d.tx_ptr   = lowest_en(tx_chan_en);
                s_d.tx_right = 1'b0;
              end
              respond = 1'b1;
            end else if (|rx_fl_hit) begin
              s_d.rx_flush = pwdata[isf_pkg::CMD_BIT] ? rx_fl_hit : 4'h0;
              respond      = 1'b1;
            end else if (|tx_fl_hit) begin
              s_d.tx_flush = pwdata[isf_pkg::CMD_BIT] ? tx_fl_hit : 4'h0;
              respond      = 1'b1;
            end else if (|thr_hit) begin
              for (int c = 0; c < isf_pkg::NCHAN; c++) begin
                if (thr_hit[c]) begin
                  s_d.thr[c*isf_pkg::THR_W +: isf_pkg::THR_W] = pwdata[isf_pkg::THR_W-1:0];
                end
              end
              respond = 1'b1;
            end else if (paddr == isf_pkg::PARAM2_OFF || paddr == isf_pkg::PARAM1_OFF ||
                         paddr == isf_pkg::VERSION_OFF || paddr == isf_pkg::RX_DMA_OFF) begin
              respond = 1'b1;
            end else begin
              respond = 1'b1;
              err     = 1'b1;
            end
          end else begin
            if (paddr == isf_pkg::RX_DMA_OFF) begin
              if (rx_chan_en == 4'h0) begin
                respond = 1'b1;
                err     = 1'b1;
              end else if (rx_word_valid[rx_ch]) begin
                // an empty head leaves respond low, so the access waits
                // rx left then right, ascending
                s_d.prdata        = rx_word_data[32*rx_ch +: 32];
                s_d.rx_pop[rx_ch] = 1'b1;
                s_d.rx_right      = !s_q.rx_right;
                if (s_q.rx_right) begin
                  s_d.rx_ptr = next_en(rx_ch, rx_chan_en);
                end else begin
                  s_d.rx_ptr = rx_ch;
                end
                respond = 1'b1;
              end
            end else if (paddr == isf_pkg::PARAM2_OFF) begin
              s_d.prdata = param2;
              respond    = 1'b1;
            end else if (paddr == isf_pkg::PARAM1_OFF) begin
              s_d.prdata = param1;
              respond    = 1'b1;
            end else if (paddr == isf_pkg::VERSION_OFF) begin
              s_d.prdata = isf_pkg::VERSION_VAL;
              respond    = 1'b1;
            end else if (|thr_hit) begin
              for (int c = 0; c < isf_pkg::NCHAN; c++) begin
                if (thr_hit[c]) begin
                  s_d.prdata = {28'h000_0000, s_q.thr[c*isf_pkg::THR_W +: isf_pkg::THR_W]};
                end
              end
              respond = 1'b1;
            end else if (|rx_fl_hit || |tx_fl_hit || paddr == isf_pkg::TX_DMA_OFF ||
                         paddr == isf_pkg::RX_PTR_RST_OFF || paddr == isf_pkg::TX_PTR_RST_OFF) begin
              // write-only registers read as zero
              respond = 1'b1;
            end else begin
              respond = 1'b1;
              err     = 1'b1;
            end
          end
        end
      end
      isf_pkg::ST_RESP: begin
        // the master still holds its request here; ignoring it keeps one answer per access
        s_d.st = isf_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = isf_pkg::ST_IDLE;
      end
    endcase

    // one-cycle completion of the access phase
    if (respond) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = err;
      s_d.st      = isf_pkg::ST_RESP;
      if (err) begin
        s_d.prdata = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= isf_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign rx_word_pop        = s_q.rx_pop;
  assign rx_flush_strobe    = s_q.rx_flush;
  assign tx_flush_strobe    = s_q.tx_flush;
  assign tx_empty_threshold = s_q.thr;
  assign tx_word_data       = s_q.e0.d;
  assign tx_word_chan       = s_q.e0.ch;
  assign tx_word_right      = s_q.e0.rt;
  assign tx_word_valid      = s_q.e0.v;

endmodule // isf_regs

`default_nettype wire

// [include/isf_pkg.sv]
/*
  Constants and types for the audio register slice: the register map,
  build-parameter field codes, and the packed state of the block.
  Assumes a 12-bit byte address on the peripheral bus and 32-bit data.
*/
`default_nettype none

package isf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets
  localparam logic [11:0] TX_THR0_OFF    = 12'h04c;
  localparam logic [11:0] RX_FLUSH0_OFF  = 12'h050;
  localparam logic [11:0] TX_FLUSH0_OFF  = 12'h054;
  localparam logic [11:0] CHAN_STRIDE    = 12'h040;
  localparam logic [11:0] RX_DMA_OFF     = 12'h1c0;
  localparam logic [11:0] RX_PTR_RST_OFF = 12'h1c4;
  localparam logic [11:0] TX_DMA_OFF     = 12'h1c8;
  localparam logic [11:0] TX_PTR_RST_OFF = 12'h1cc;
  localparam logic [11:0] PARAM2_OFF     = 12'h1f0;
  localparam logic [11:0] PARAM1_OFF     = 12'h1f4;
  localparam logic [11:0] VERSION_OFF    = 12'h1f8;

  // channel count, control bit position, threshold width and reset value
  localparam int          NCHAN          = 4;
  localparam int          CMD_BIT        = 0;
  localparam int          THR_W          = 4;
  localparam logic [3:0]  THR_RST        = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // word size codes
  localparam logic [2:0]  WS_12          = 3'h0;
  localparam logic [2:0]  WS_16          = 3'h1;
  localparam logic [2:0]  WS_20          = 3'h2;
  localparam logic [2:0]  WS_24          = 3'h3;
  localparam logic [2:0]  WS_32          = 3'h4;

  // build values reported in the parameter registers
  localparam logic [2:0]  RX_WS0         = WS_32;
  localparam logic [2:0]  RX_WS1         = WS_32;
  localparam logic [2:0]  RX_WS2         = WS_32;
  localparam logic [2:0]  RX_WS3         = WS_32;
  localparam logic [2:0]  TX_WS0         = WS_32;
  localparam logic [2:0]  TX_WS1         = WS_32;
  localparam logic [2:0]  TX_WS2         = WS_32;
  localparam logic [2:0]  TX_WS3         = WS_32;
  localparam logic [1:0]  TX_CHAN_CODE   = 2'h3;
  localparam logic [1:0]  RX_CHAN_CODE   = 2'h3;
  localparam logic        HAS_RX_BLOCK   = 1'h1;
  localparam logic        HAS_TX_BLOCK   = 1'h1;
  localparam logic        MODE_EN        = 1'h1;
  localparam logic [1:0]  FIFO_DEPTH_CODE = 2'h3;
  localparam logic [1:0]  BUS_WIDTH_CODE = 2'h2;
  // arbitrary value, not tied to any release
  localparam logic [31:0] VERSION_VAL    = 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } isf_st_t;

  typedef struct packed {
    logic        v;
    logic [1:0]  ch;
    logic        rt;
    logic [31:0] d;
  } isf_txent_t;

  typedef struct packed {
    isf_st_t     st;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [1:0]  rx_ptr;
    logic        rx_right;
    logic [1:0]  tx_ptr;
    logic        tx_right;
    logic [3:0]  rx_pop;
    logic [3:0]  rx_flush;
    logic [3:0]  tx_flush;
    logic [15:0] thr;
    isf_txent_t  e0;
    isf_txent_t  e1;
  } isf_state_t;

  localparam isf_state_t STATE_RST = '{st: ST_IDLE, thr: {4{THR_RST}}, default: '0};

endpackage

`default_nettype wire

// [bench/isf_regs_props.sv]
/* checker for the audio register slice: bus pulses, strobes, dma words, fixed reads
   assumes one clock mclk and the async high reset rst of isf_regs */
`timescale 1ns/1ps
`default_nettype none
module isf_regs_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // bus side
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // channel side
  input wire logic [3:0]  rx_word_pop,
  input wire logic [3:0]  rx_flush_strobe,
  input wire logic [3:0]  tx_flush_strobe,
  input wire logic [15:0] tx_empty_threshold,
  input wire logic [31:0] tx_word_data,
  input wire logic        tx_word_valid,
  input wire logic        tx_word_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_flush_rx_pulse: assert property (
    |rx_flush_strobe |-> pready && pwrite && !pslverr && $onehot(rx_flush_strobe)) else $error("rx flush stray");
  a_flush_tx_pulse: assert property (
    |tx_flush_strobe |-> pready && pwrite && !pslverr && $onehot(tx_flush_strobe)) else $error("tx flush stray");
  a_pop_one_word: assert property (
    |rx_word_pop |-> pready && !pwrite && paddr == isf_pkg::RX_DMA_OFF && $onehot(rx_word_pop))
    else $error("rx pop stray");
  a_pop_then_rest: assert property (
    |rx_word_pop |=> rx_word_pop == 4'h0) else $error("rx pop longer than a cycle");
  a_tx_word_hold: assert property (
    tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word_data)) else $error("tx word dropped");
  a_version_fixed: assert property (
    pready && !pwrite && paddr == isf_pkg::VERSION_OFF |-> prdata == isf_pkg::VERSION_VAL)
    else $error("version changed");
  a_rx_sizes_rsvd: assert property (
    pready && !pwrite && paddr == isf_pkg::PARAM2_OFF |-> prdata[31:13] == 19'h0_0000 && !prdata[6])
    else $error("reserved sizes bits set");
  a_width_code_ok: assert property (
    pready && !pwrite && paddr == isf_pkg::PARAM1_OFF |-> prdata[1:0] != 2'h3 && prdata[31:28] == 4'h0)
    else $error("bad main parameter read");
  a_thr_after_rst: assert property (
    $fell(rst) |-> tx_empty_threshold == 16'h3333) else $error("threshold reset value");
endmodule // isf_regs_props
bind isf_regs isf_regs_props isf_regs_props_inst (
  .mclk(mclk), .rst(rst), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_word_pop(rx_word_pop), .rx_flush_strobe(rx_flush_strobe),
  .tx_flush_strobe(tx_flush_strobe), .tx_empty_threshold(tx_empty_threshold),
  .tx_word_data(tx_word_data), .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready)
);
`default_nettype wire

// [bench/isf_chan_model.sv]
/* channel-side model: four receive fifo heads and a transmit sink, both able to stall
   assumes lazy comes from the bench, bit 0 slows rx heads, bit 1 stalls tx */
`timescale 1ns/1ps
`default_nettype none
module isf_chan_model (
  // clock, reset and stall pattern
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [1:0]  lazy,
  // receive fifo heads
  input  wire logic [3:0]  rx_word_pop,
  output logic [127:0]     rx_word_data,
  output logic [3:0]       rx_word_valid,
  // transmit sink
  output logic             tx_word_ready
);
  logic [23:0] cnt_q [4];
  // one head word a channel, next word only after a pop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '{default: '0};
      rx_word_valid <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (rx_word_pop[c]) begin
          cnt_q[c] <= cnt_q[c] + 24'h00_0001;
          rx_word_valid[c] <= 1'b0;
        end else if (!lazy[0]) begin
          rx_word_valid[c] <= 1'b1;
        end
      end
    end
  end
  // empty heads show the inverted word, never a stale one
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      rx_word_data[32*c +: 32] = {6'h00, 2'(c), cnt_q[c]} ^ {32{!rx_word_valid[c]}};
    end
  end
  // slow sink refuses whenever its stall bit is set
  assign tx_word_ready = !lazy[1];
endmodule // isf_chan_model
`default_nettype wire

// [bench/tb_isf_regs.sv]
/* self-checking bench for isf_regs: bus task, random enables and stalls, dma streams
   assumes isf_chan_model on the channel side and the bound checker */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb_isf_regs;
  logic         mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, rt;
  logic         tx_word_right, tx_word_valid, tx_word_ready;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, r, tx_word_data;
  logic [3:0]   rx_chan_en = '0, tx_chan_en = '0, rx_word_valid, rx_word_pop, rxf, txf;
  logic [3:0]   rx_flush_strobe, tx_flush_strobe;
  logic [127:0] rx_word_data;
  logic [15:0]  tx_empty_threshold, lf = 16'h000c, lz = 16'h000c;
  logic [1:0]   tx_word_chan, lazy = '0, ch;
  logic [23:0]  cnt [4] = '{default: '0};
  logic [34:0]  txq [$];
  int           mismatches = 0, compares = 0, cyc = 0;
  isf_regs isf_regs_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_chan_en(rx_chan_en), .tx_chan_en(tx_chan_en),
    .rx_word_data(rx_word_data), .rx_word_valid(rx_word_valid), .rx_word_pop(rx_word_pop),
    .rx_flush_strobe(rx_flush_strobe), .tx_flush_strobe(tx_flush_strobe),
    .tx_empty_threshold(tx_empty_threshold),
    .tx_word_data(tx_word_data), .tx_word_chan(tx_word_chan), .tx_word_right(tx_word_right),
    .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready)
  );
  isf_chan_model isf_chan_model_inst (
    .mclk(mclk), .rst(rst), .lazy(lazy), .rx_word_pop(rx_word_pop),
    .rx_word_data(rx_word_data), .rx_word_valid(rx_word_valid), .tx_word_ready(tx_word_ready)
  );
  always #20 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // next enabled channel above cur, wrapping; from 3 it gives the lowest
  function automatic logic [1:0] nxt(input logic [3:0] en, input logic [1:0] cur);
    for (int i = 1; i <= 4; i++) if (en[2'(cur + i)]) return 2'(cur + i);
    return cur;
  endfunction
  task automatic close_out;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one bus access, held until pready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1 psel = 1; pwrite = w; paddr = a; pwdata = d;
    @(posedge mclk);
    #1 penable = 1;
    @(negedge mclk);
    while (pready !== 1'b1) @(negedge mclk);
    r = prdata; e = pslverr; rxf = rx_flush_strobe; txf = tx_flush_strobe;
    @(posedge mclk);
    #1 psel = 0; penable = 0;
  endtask
  task automatic rx_read(input int n);
    repeat (n) begin
      bus(0, 12'h1c0, 0);
      `CHK({e, r}, {1'b0, 6'h00, ch, cnt[ch]})
      cnt[ch]++;
      if (rt) ch = nxt(rx_chan_en, ch);
      rt = ~rt;
    end
  endtask
  task automatic tx_write(input int n);
    repeat (n) begin
      lf = lfsr(lf);
      txq.push_back({ch, rt, lf, ~lf});
      bus(1, 12'h1c8, {lf, ~lf});
      if (rt) ch = nxt(tx_chan_en, ch);
      rt = ~rt;
    end
  endtask
  // words leaving the transmit buffer
  always @(negedge mclk) if (tx_word_valid === 1'b1 && tx_word_ready === 1'b1)
    `CHK({tx_word_chan, tx_word_right, tx_word_data}, txq.pop_front())
  // random stalls and the hang limit
  always @(posedge mclk) begin
    #1 lazy = lz[1:0];
    lz = lfsr(lz);
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst = 0;
    `CHK(tx_empty_threshold, 16'h3333)
    bus(1, 12'h08c, 32'h0000_0009);
    `CHK(tx_empty_threshold[7:4], 4'h9)
    bus(0, 12'h08c, 0);
    `CHK(r, 32'h0000_0009)
    bus(0, 12'h1f0, 0);
    `CHK(r, 32'h0000_1224)
    bus(0, 12'h1f4, 0);
    `CHK(r, {4'h0, {4{3'h4}}, 5'h0, 4'hf, 3'h7, 2'h3, 2'h2})
    bus(1, 12'h1f8, 32'hffff_ffff);
    bus(0, 12'h1f8, 0);
    `CHK(r, isf_pkg::VERSION_VAL)
    bus(0, 12'h100, 0);
    `CHK({e, r}, 33'h1_0000_0000)
    for (int c = 0; c < 4; c++) begin
      bus(1, 12'(80 + 64 * c), 1);
      `CHK(rxf, 4'(1 << c))
      bus(1, 12'(84 + 64 * c), 1);
      `CHK(txf, 4'(1 << c))
      bus(0, 12'(80 + 64 * c), 0);
      `CHK(r, 32'h0000_0000)
    end
    bus(0, 12'h1c0, 0);
    `CHK(e, 1'b1)
    bus(1, 12'h1c8, 32'h0000_0000);
    `CHK(e, 1'b1)
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      rx_chan_en = (k == 0) ? 4'h8 : ((lf[3:0] == 0) ? 4'h5 : lf[3:0]);
      tx_chan_en = (k == 0) ? 4'hf : ((lf[7:4] == 0) ? 4'h2 : lf[7:4]);
      for (int h = 3; h < 12; h += 6) begin
        bus(1, 12'h1c4, 1);
        ch = nxt(rx_chan_en, 2'd3);
        rt = 0;
        rx_read(h);
        bus(1, 12'h1cc, 1);
        ch = nxt(tx_chan_en, 2'd3);
        rt = 0;
        tx_write(h);
      end
    end
    repeat (100) @(posedge mclk);
    `CHK(txq.size(), 0)
    close_out;
  end
endmodule // tb_isf_regs
`default_nettype wire
